// file: bench/adcsq_checker.sv
// Assertions on the converter sequencer's ports.
// Assumes the bench holds rstn low for at least two clock edges.
`timescale 1ns/1ns
`default_nettype none
module adcsq_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Watched signals
  input wire logic       conv_enable,
  input wire logic [3:0] mux_pos_q,
  input wire logic [3:0] mux_neg_q,
  input wire logic       sample_clk_en_q,
  input wire logic [4:0] event_flags_q,
  input wire logic [4:0] event_flags_clr,
  input wire logic [4:0] event_enables,
  input wire logic       conv_irq_q,
  input wire logic       dma_running_q,
  input wire logic       ram_we_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reset_values: assert property (disable iff (1'b0)
    !rstn |=> mux_pos_q == 4'h8
    && mux_neg_q == 4'h9 && event_flags_q == 5'h00)
    else $error("reset values wrong");
  a_mux_legal_code: assert property (!(mux_pos_q inside {[6:7], [12:15]})
    && !(mux_neg_q inside {[6:7], [12:15]})) else $error("illegal mux code");
  a_irq_masked_or: assert property (1 |=> conv_irq_q ==
    |($past(event_flags_q) & $past(event_enables))) else $error("irq wrong");
  a_flags_sticky: assert property (1 |=> (($past(event_flags_q)
    & ~$past(event_flags_clr)) & ~event_flags_q) == 5'h00)
    else $error("flag lost without clear");
  a_settle_quiet: assert property ($rose(conv_enable)
    && !event_flags_q[4] |=> !event_flags_q[4] [*8])
    else $error("data during settling");
  a_full_on_write: assert property ($rose(event_flags_q[2])
    |-> ram_we_q || $past(ram_we_q) || $past(ram_we_q, 2))
    else $error("full without write");
  a_half_on_write: assert property ($rose(event_flags_q[3])
    |-> ram_we_q || $past(ram_we_q) || $past(ram_we_q, 2))
    else $error("half without write");
  a_tick_spacing: assert property (sample_clk_en_q
    |=> !sample_clk_en_q [*2]) else $error("ticks too close");
  a_ovf_no_dma: assert property ($rose(event_flags_q[0])
    |-> !$past(dma_running_q)) else $error("overflow while dma ran");
endmodule
bind adcsq_top adcsq_checker u_adcsq_checker (.clk, .rstn, .conv_enable,
  .mux_pos_q, .mux_neg_q, .sample_clk_en_q, .event_flags_q, .event_flags_clr,
  .event_enables, .conv_irq_q, .dma_running_q, .ram_we_q);
`default_nettype wire

// file: bench/adcsq_mod_model.sv
// Far side: modulator count source and RAM write port with stalls.
// Assumes the bench sets the count level and the stall request.
`timescale 1ns/1ns
`default_nettype none
module adcsq_mod_model (
  // Control from bench
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [15:0] level,
  // Modulator and RAM
  output logic [15:0]      raw_result,
  input  wire logic        ram_we_q,
  input  wire logic [15:0] ram_addr_q,
  input  wire logic [15:0] ram_wdata_q,
  output logic             ram_ready,
  output logic [15:0]      last_addr,
  output logic [15:0]      last_data
);
  assign raw_result = level;
  // Stalling RAM accepts only every other cycle; a write pulse was
  // already accepted when the design drained, so it is always taken
  always @(posedge clk) begin
    ram_ready <= stall ? ~ram_ready : 1'b1;
    if (ram_we_q) begin
      last_addr <= ram_addr_q;
      last_data <= ram_wdata_q;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the converter sequencer.
// Assumes settling shortened to 20 cycles; the fresh-enable timing is derived from it.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int ST = 20;
  localparam int T0 = 32 * 41;
  logic clk = 0, rstn = 0, conv_enable = 0, slow_sample_clock_sel = 0;
  logic cfg_write = 0, osc_switch = 0, sample_clk_en_q, conv_irq_q;
  logic [3:0] pos_input_select = 4'h8, neg_input_select = 4'h9;
  logic [3:0] mux_pos_q, mux_neg_q, ep, en;
  logic [2:0] period_sel = 3'h0;
  logic [15:0] offset_val = 16'h0000, gain_val = 16'h8000, level = 16'h1234;
  logic [15:0] raw_result, result_q, dma_cur_addr_q, ram_addr_q, ram_wdata_q;
  logic [15:0] buffer_start_addr = 16'h0100, buffer_sample_count = 16'h0002;
  logic [15:0] last_addr, last_data;
  logic [4:0] event_flags_q, event_flags_clr = 5'h00, event_enables = 5'h00;
  logic sample_dma_reset = 0, sample_dma_start = 0, sample_dma_wrap_mode = 0;
  logic dma_running_q, ram_we_q, ram_ready, stall = 0;
  int num_errors = 0, check_count = 0, n;
  always #2 clk = ~clk;
  adcsq_top #(.SETTLE_CYCLES(ST)) u_adcsq_top (.clk, .rstn, .conv_enable,
    .pos_input_select, .neg_input_select, .slow_sample_clock_sel,
    .period_sel, .cfg_write, .osc_switch, .offset_val, .gain_val,
    .raw_result, .mux_pos_q, .mux_neg_q, .sample_clk_en_q, .result_q,
    .event_flags_q, .event_flags_clr, .event_enables, .conv_irq_q,
    .sample_dma_reset, .sample_dma_start, .sample_dma_wrap_mode,
    .buffer_start_addr, .buffer_sample_count, .dma_running_q,
    .dma_cur_addr_q, .ram_we_q, .ram_addr_q, .ram_wdata_q, .ram_ready);
  adcsq_mod_model u_adcsq_mod_model (.clk, .stall, .level, .raw_result,
    .ram_we_q, .ram_addr_q, .ram_wdata_q, .ram_ready, .last_addr,
    .last_data);
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_win(string nm, int e, int g);
    check_count++;
    if (g < e - 16 || g > e + 16) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Reads the flags at each edge, before that edge updates them
  task automatic wait_bit(int b);
    n = 0;
    @(posedge clk);
    while (event_flags_q[b] !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Fires enable, config write or oscillator switch; times the first result
  task automatic kick(int k, int e);
    @(posedge clk);
    case (k)
      0: conv_enable <= 1'b1;
      1: cfg_write <= 1'b1;
      default: osc_switch <= 1'b1;
    endcase
    event_flags_clr <= 5'h10;
    @(posedge clk);
    {cfg_write, osc_switch, event_flags_clr} <= 7'h00;
    wait_bit(4);
    chk_win("first result time", e, n + 1);
  endtask
  task automatic t_mux;
    ep = 4'h8;
    en = 4'h9;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      pos_input_select <= 4'(c);
      neg_input_select <= 4'(15 - c);
      cfg_write <= 1'b1;
      @(posedge clk);
      cfg_write <= 1'b0;
      repeat (3) @(posedge clk);
      if (c <= 5 || (c >= 8 && c <= 11)) ep = 4'(c);
      if ((c >= 4 && c <= 7) || c >= 10) en = 4'(15 - c);
      chk("mux_pos_q", 16'(ep), 16'(mux_pos_q));
      chk("mux_neg_q", 16'(en), 16'(mux_neg_q));
    end
    $display("test mux done");
  endtask
  task automatic t_events;
    kick(0, ST + 2 * T0);
    chk("result", 16'h0900, result_q);
    chk("ovf", 16'h1, 16'(event_flags_q[0]));
    @(posedge clk);
    event_flags_clr <= 5'h00;
    repeat (2) @(posedge clk);
    chk("flags zero write", 16'h11, 16'(event_flags_q & 5'h11));
    chk("irq masked", 16'h0, 16'(conv_irq_q));
    event_enables <= 5'h10;
    repeat (2) @(posedge clk);
    chk("irq enabled", 16'h1, 16'(conv_irq_q));
    event_enables <= 5'h00;
    event_flags_clr <= 5'h01;
    @(posedge clk);
    event_flags_clr <= 5'h00;
    @(posedge clk);
    chk("ovf cleared", 16'h0, 16'(event_flags_q[0]));
    $display("test events done");
  endtask
  task automatic t_timing;
    kick(1, 2 * T0);
    kick(2, 2 * T0);
    gain_val <= 16'hFFFF;
    level <= 16'h6000;
    kick(1, 2 * T0);
    chk("sat result", 16'h3FFF, result_q);
    chk("sat flag", 16'h1, 16'(event_flags_q[1]));
    gain_val <= 16'h8000;
    level <= 16'h1234;
    slow_sample_clock_sel <= 1'b1;
    kick(1, 2 * 32 * 250);
    slow_sample_clock_sel <= 1'b0;
    period_sel <= 3'h1;
    kick(1, 2 * 64 * 41);
    period_sel <= 3'h0;
    $display("test timing done");
  endtask
  task automatic t_dma;
    @(posedge clk);
    sample_dma_reset <= 1'b1;
    stall <= 1'b1;
    @(posedge clk);
    sample_dma_reset <= 1'b0;
    sample_dma_start <= 1'b1;
    event_flags_clr <= 5'h0F;
    @(posedge clk);
    {sample_dma_start, event_flags_clr} <= 6'h00;
    wait_bit(2);
    repeat (2) @(posedge clk);
    chk("half", 16'h1, 16'(event_flags_q[3]));
    chk("last addr", 16'h0102, last_addr);
    chk("ram data", 16'h0900, last_data);
    chk("dma stopped", 16'h0, 16'(dma_running_q));
    chk("no ovf yet", 16'h0, 16'(event_flags_q[0]));
    wait_bit(0);
    chk("later ovf", 16'h1, 16'(event_flags_q[0]));
    $display("test dma done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("reset flags", 16'h0, 16'(event_flags_q));
    t_mux;
    pos_input_select <= 4'h0;
    neg_input_select <= 4'h9;
    t_events;
    t_timing;
    t_dma;
    summarize;
  end
  initial begin
    #300000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire

// file: design/adcsq_fifo.sv
// Synchronous FIFO between the result datapath and the sample DMA.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ns
`default_nettype none
module adcsq_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: design/adcsq_top.sv
// Converter sequencer: sample timing, startup, correction, events, DMA.
// Assumes modulator count arrives on the system clock; RAM always accepts
// unless ram_ready is low.
`timescale 1ns/1ns
`default_nettype none
module adcsq_top #(
  parameter int unsigned SETTLE_CYCLES = adcsq_pkg::SETTLE_CYC,
  parameter int unsigned FIFO_DEPTH    = 32,
  parameter int unsigned ADDR_W        = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Configuration
  input  wire logic              conv_enable,
  input  wire logic [3:0]        pos_input_select,
  input  wire logic [3:0]        neg_input_select,
  input  wire logic              slow_sample_clock_sel,
  input  wire logic [2:0]        period_sel,
  input  wire logic              cfg_write,
  input  wire logic              osc_switch,
  input  wire logic [15:0]       offset_val,
  input  wire logic [15:0]       gain_val,
  // Modulator
  input  wire logic [15:0]       raw_result,
  output logic [3:0]             mux_pos_q,
  output logic [3:0]             mux_neg_q,
  output logic                   sample_clk_en_q,
  // Result and events
  output logic [15:0]            result_q,
  output logic [4:0]             event_flags_q,
  input  wire logic [4:0]        event_flags_clr,
  input  wire logic [4:0]        event_enables,
  output logic                   conv_irq_q,
  // Sample DMA
  input  wire logic              sample_dma_reset,
  input  wire logic              sample_dma_start,
  input  wire logic              sample_dma_wrap_mode,
  input  wire logic [ADDR_W-1:0] buffer_start_addr,
  input  wire logic [ADDR_W-1:0] buffer_sample_count,
  output logic                   dma_running_q,
  output logic [ADDR_W-1:0]      dma_cur_addr_q,
  // RAM write port
  output logic                   ram_we_q,
  output logic [ADDR_W-1:0]      ram_addr_q,
  output logic [15:0]            ram_wdata_q,
  input  wire logic              ram_ready
);
  function automatic logic mux_ok(input logic [3:0] c);
    mux_ok = (c <= adcsq_pkg::MUX_IN_LAST) || (c == adcsq_pkg::MUX_GND)
          || (c == adcsq_pkg::MUX_HALF_REF) || (c == adcsq_pkg::MUX_REF)
          || (c == adcsq_pkg::MUX_HALF_PADS);
  endfunction

  adcsq_pkg::adcsq_state_t st_q;
  adcsq_pkg::adcsq_state_t st_d;
  logic [7:0]  div_q;
  logic [15:0] settle_q;
  logic [12:0] scnt_q;
  logic [ADDR_W-1:0] idx_q;

  // Sample clock divider; fixed to the system clock, not the oscillator
  wire [7:0] div_max = slow_sample_clock_sel ?          // [RULE2] [RULE5]
    8'(adcsq_pkg::SLOW_DIV - 1) : 8'(adcsq_pkg::FAST_DIV - 1);
  wire sclk_tick = (div_q >= div_max);
  wire [12:0] sample_len =                              // [RULE3]
    13'(adcsq_pkg::BASE_SAMPLE_CLKS) << period_sel;
  // Greater-or-equal so a shorter period mid-sample cannot miss the end
  wire sample_done = sclk_tick && (scnt_q >= sample_len - 13'h0001);
  wire reconfig = cfg_write || osc_switch;              // [RULE15] [RULE16]
  // Divider and sample count restart together so every sample is full length
  wire seq_hold = (st_q == adcsq_pkg::ADCSQ_IDLE)
               || (st_q == adcsq_pkg::ADCSQ_SETTLE) || reconfig;

  // Valid bits = 7 + period code, left aligned
  wire [4:0] vbits = 5'(adcsq_pkg::BASE_VALID_BITS) + 5'(period_sel);
  wire [15:0] vmask = 16'hFFFF << (5'd16 - vbits);      // [RULE4]
  wire [15:0] aligned = raw_result & vmask;

  // Offset, gain, clamp, halve
  wire signed [16:0] offs = $signed({aligned[15], aligned})
                          + $signed({offset_val[15], offset_val});
  wire signed [33:0] prod = offs * $signed({1'b0, gain_val});
  wire signed [18:0] scaled = prod[33:15];
  wire sat_hi = scaled > $signed({3'h0, adcsq_pkg::SAT_POS});
  wire sat_lo = scaled < -$signed({3'h0, adcsq_pkg::SAT_NEG});
  wire [15:0] clamped = sat_hi ? adcsq_pkg::SAT_POS :   // [RULE24]
                        sat_lo ? adcsq_pkg::SAT_NEG : scaled[15:0];
  wire [15:0] corrected = {clamped[15], clamped[15:1]};

  wire result_ev = (st_q == adcsq_pkg::ADCSQ_RUN) && sample_done
                   && !reconfig;
  wire discard_ev = (st_q == adcsq_pkg::ADCSQ_DISCARD) && sample_done;

  // Sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      adcsq_pkg::ADCSQ_IDLE:
        if (conv_enable) st_d = adcsq_pkg::ADCSQ_SETTLE; // [RULE14]
      adcsq_pkg::ADCSQ_SETTLE:
        if (settle_q == 16'(SETTLE_CYCLES - 1))          // [RULE26]
          st_d = adcsq_pkg::ADCSQ_DISCARD;               // [RULE17]
      adcsq_pkg::ADCSQ_DISCARD:
        if (discard_ev && !reconfig) st_d = adcsq_pkg::ADCSQ_RUN;
      adcsq_pkg::ADCSQ_RUN:
        if (reconfig) st_d = adcsq_pkg::ADCSQ_DISCARD;   // [RULE15]
      default: st_d = adcsq_pkg::ADCSQ_IDLE;
    endcase
    if (!conv_enable) st_d = adcsq_pkg::ADCSQ_IDLE;      // [RULE13]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q      <= adcsq_pkg::ADCSQ_IDLE;
      div_q     <= '0;
      settle_q  <= '0;
      scnt_q    <= '0;
    end else begin
      st_q      <= st_d;
      div_q     <= (sclk_tick || seq_hold) ? 8'h00 : div_q + 8'h01;
      settle_q  <= (st_q == adcsq_pkg::ADCSQ_SETTLE) ? settle_q + 16'h0001
                                                     : 16'h0000;
      if (seq_hold || sample_done) begin
        scnt_q <= '0;
      end else if (sclk_tick) begin
        scnt_q <= scnt_q + 13'h0001;
      end
    end
  end

  // Modulator controls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mux_pos_q       <= adcsq_pkg::MUX_GND;
      mux_neg_q       <= adcsq_pkg::MUX_HALF_REF;
      sample_clk_en_q <= 1'b0;
    end else begin
      if (mux_ok(pos_input_select)) mux_pos_q <= pos_input_select; // [RULE1]
      if (mux_ok(neg_input_select)) mux_neg_q <= neg_input_select; // [RULE1]
      sample_clk_en_q <= sclk_tick && (st_q == adcsq_pkg::ADCSQ_DISCARD
                         || st_q == adcsq_pkg::ADCSQ_RUN);
    end
  end

  // FIFO toward RAM; a full FIFO counts as the DMA not keeping up
  logic        f_in_ready;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  wire         f_out_ready = ram_ready && dma_running_q;
  wire         dma_accept = result_ev && dma_running_q && f_in_ready;
  wire         last_idx  = (idx_q == buffer_sample_count - 1'b1);   // [RULE25]
  wire         half_idx  = (idx_q == (buffer_sample_count >> 1) - 1'b1);
  wire         drain = f_out_valid && f_out_ready;

  adcsq_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (sample_dma_reset),
    .in_valid  (dma_accept),
    .in_ready  (f_in_ready),
    .in_data   (corrected),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Sample DMA; config writes leave it running
  always_ff @(posedge clk) begin
    if (!rstn || sample_dma_reset) begin
      dma_running_q  <= 1'b0;
      idx_q          <= '0;
      dma_cur_addr_q <= '0;
      ram_we_q       <= 1'b0;
      ram_addr_q     <= '0;
      ram_wdata_q    <= '0;
    end else begin
      ram_we_q <= drain;
      if (sample_dma_start && !dma_running_q) begin     // [RULE18]
        dma_running_q  <= 1'b1;
        idx_q          <= '0;
        dma_cur_addr_q <= buffer_start_addr;
      end else if (drain) begin
        ram_addr_q  <= dma_cur_addr_q;
        ram_wdata_q <= f_out_data;
        if (last_idx) begin
          idx_q          <= '0;
          dma_cur_addr_q <= buffer_start_addr;
          dma_running_q  <= sample_dma_wrap_mode;       // [RULE22] [RULE23]
        end else begin
          idx_q          <= idx_q + 1'b1;
          dma_cur_addr_q <= dma_cur_addr_q + ADDR_W'(2);
        end
      end
    end
  end

  // Events; a set in the same cycle beats the clear
  logic [4:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[adcsq_pkg::EV_OVF]  = result_ev && !dma_accept;     // [RULE6]
    ev_set[adcsq_pkg::EV_SAT]  = result_ev && (sat_hi || sat_lo); // [RULE7]
    ev_set[adcsq_pkg::EV_FULL] = drain && last_idx;            // [RULE8]
    ev_set[adcsq_pkg::EV_HALF] = drain && half_idx;            // [RULE9]
    ev_set[adcsq_pkg::EV_DATA] = result_ev;                    // [RULE10]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      event_flags_q <= '0;
      conv_irq_q    <= 1'b0;
      result_q      <= '0;
    end else begin
      event_flags_q <= (event_flags_q & ~event_flags_clr) | ev_set; // [RULE11]
      conv_irq_q    <= |(event_flags_q & event_enables);         // [RULE12]
      if (result_ev) result_q <= corrected;
    end
  end
endmodule
`default_nettype wire

// file: inc/adcsq_pkg.sv
// Constants for the converter sequencer and event control.
// Assumes one 250 MHz system clock; all slower rates are enable pulses.
// Contract
// RULE1: Input selects pass codes 0-5, 8 ground, 9 half ref, 10 ref, 11.
// RULE2: Slow select clear uses 6 MHz sample clock, set uses 1 MHz.
// RULE3: Period code n gives 32 times two to the n sample clocks.
// RULE4: Results are 16-bit words, valid bits left aligned, 7 plus code.
// RULE5: Sample timing does not depend on which system oscillator runs.
// RULE6: Overflow flag sets when a result is ready and DMA not running.
// RULE7: Saturation flag sets when gain product leaves signed 16-bit range.
// RULE8: Full flag sets when DMA writes the last buffer location.
// RULE9: Half flag sets when DMA writes last location of lower half.
// RULE10: Data-ready flag sets on each new corrected result.
// RULE11: Flags clear only on write of one; zero writes do nothing.
// RULE12: Interrupt asserts only for set flags with matching enable bit.
// RULE13: While enabled, conversions run back to back continuously.
// RULE14: Enabling from disabled inserts a 21 us settling delay first.
// RULE15: After enable or config write, first conversion is discarded.
// RULE16: System oscillator switch triggers the same discard cycle.
// RULE17: Fresh enable: first result after settling plus doubled sample time.
// RULE18: Config writes do not stop a running sample DMA.
// RULE19: Software stops DMA before reconfiguring and clears overflow after.
// RULE20: Polled use: zero enables, configure, clear data flag, wait, read.
// RULE21: Polled DMA use: reset DMA, size 1, enable, clear full, wrap, wait.
// RULE22: DMA mode bit zero is linear, one is auto-wrap.
// RULE23: Linear DMA stops after the count and sets full; later overflows.
// RULE24: Gain product clamps to 0x7FFF or 0x8000 before final halving.
// RULE25: Buffer size counts 16-bit samples, not bytes.
// RULE26: Settling is counted from a fixed reference; data-ready stays clear.
package adcsq_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned FAST_SCLK_MHZ = 6;
  localparam int unsigned SLOW_SCLK_MHZ = 1;
  // Divider counts per sample clock, rounded down to the nearest whole cycle
  localparam int unsigned FAST_DIV = CLK_MHZ / FAST_SCLK_MHZ;
  localparam int unsigned SLOW_DIV = CLK_MHZ / SLOW_SCLK_MHZ;
  localparam int unsigned SETTLE_NS = 21000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BASE_SAMPLE_CLKS = 32;
  localparam int unsigned BASE_VALID_BITS  = 7;
  localparam logic [3:0] MUX_IN_LAST   = 4'h5;
  localparam logic [3:0] MUX_GND       = 4'h8;
  localparam logic [3:0] MUX_HALF_REF  = 4'h9;
  localparam logic [3:0] MUX_REF       = 4'hA;
  localparam logic [3:0] MUX_HALF_PADS = 4'hB;
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  // Event flag bit positions
  localparam int unsigned EV_OVF  = 0;
  localparam int unsigned EV_SAT  = 1;
  localparam int unsigned EV_FULL = 2;
  localparam int unsigned EV_HALF = 3;
  localparam int unsigned EV_DATA = 4;
  localparam int unsigned EV_N    = 5;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_SETTLE,
    ADCSQ_DISCARD,
    ADCSQ_RUN
  } adcsq_state_t;
endpackage
